// *** verilog/timer_control_status_irq.sv ***
// Control, status and event logic of the 16-bit timer, classic Wishbone slave
`default_nettype none
module timer_control_status_irq
  import timer_ctl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter bit HAS_EXT_CLOCK = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic capture_in_one_i,
  input wire logic capture_in_two_i,
  input wire logic ext_clock_pin_i,
  input wire logic cpu_irq_mask_i,
  input wire logic wait_mode_i,
  input wire logic halt_mode_i,
  output logic compare_out_one_o,
  output logic compare_out_one_oe_o,
  output logic compare_out_two_o,
  output logic compare_out_two_oe_o,
  output logic irq_o,
  output logic wake_o
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc;
  logic acc_ok;
  logic acc_rd;
  logic acc_wr;
  logic [IDX_W-1:0] acc_idx;

  assign acc = cyc_i && stb_i && !ack_o;
  assign acc_idx = adr_i[IDX_W+IDX_LSB-1:IDX_LSB];
  assign acc_ok = acc && (adr_i[IDX_LSB-1:0] == '0) &&
                  (adr_i[ADDR_W-1:IDX_W+IDX_LSB] == '0);
  // Writes need the low byte lane; reads ignore the lanes
  assign acc_rd = acc_ok && !we_i;
  assign acc_wr = acc_ok && we_i && sel_i[0];

  function automatic logic is_reg(input logic ok,
                                  input logic [IDX_W-1:0] a,
                                  input logic [IDX_W-1:0] idx);
    is_reg = ok && (a == idx);
  endfunction

  function automatic logic [2:0] pre_mask(input logic [1:0] sel);
    unique case (sel)
      CLK_DIV2: pre_mask = PRE_MASK_DIV2;
      CLK_DIV8: pre_mask = PRE_MASK_DIV8;
      default: pre_mask = PRE_MASK_DIV4;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic timer_disable_reg;
  logic [NUM_FLAGS-1:0] flags_reg;
  logic [NUM_FLAGS-1:0] armed_reg;
  logic [15:0] cnt_reg;
  logic [15:0] compare_value_one_reg;
  logic [15:0] compare_value_two_reg;
  logic [15:0] capture_one_reg;
  logic [15:0] capture_two_reg;
  logic cmp_one_hold_reg;
  logic cmp_two_hold_reg;
  logic [2:0] pre_reg;
  logic cap_one_prev_reg;
  logic cap_two_prev_reg;
  logic ext_prev_reg;

  logic [1:0] clock_select;
  logic run;
  logic tick;
  logic ext_edge;
  logic cap_one_edge;
  logic cap_two_edge;
  logic match_one;
  logic match_two;
  logic cnt_wr;
  logic irq_req;
  logic force_one;
  logic force_two;
  timer_mode_t mode;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_hit;

  assign clock_select = ctrl_two_reg[B_CLK_SEL_HI:B_CLK_SEL_LO];

  // PWM takes precedence when both mode bits are set
  always_comb begin
    if (ctrl_two_reg[B_PWM]) begin
      mode = MODE_PWM;
    end else if (ctrl_two_reg[B_SINGLE_PULSE]) begin
      mode = MODE_SINGLE;
    end else begin
      mode = MODE_NORMAL;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and counter clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_one_prev_reg <= 1'b0;
      cap_two_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      cap_one_prev_reg <= capture_in_one_i;
      cap_two_prev_reg <= capture_in_two_i;
      ext_prev_reg <= ext_clock_pin_i;
    end
  end

  assign cap_one_edge = ctrl_one_reg[B_CAP_ONE_EDGE] ? // [RQ8]
                        (capture_in_one_i && !cap_one_prev_reg) :
                        (!capture_in_one_i && cap_one_prev_reg);
  assign cap_two_edge = ctrl_two_reg[B_CAP_TWO_EDGE] ? // [RQ8]
                        (capture_in_two_i && !cap_two_prev_reg) :
                        (!capture_in_two_i && cap_two_prev_reg);
  assign ext_edge = ctrl_two_reg[B_EXT_EDGE] ? // [RQ15]
                    (ext_clock_pin_i && !ext_prev_reg) :
                    (!ext_clock_pin_i && ext_prev_reg);

  // Halt freezes counting so it resumes from the held count
  assign run = !timer_disable_reg && !halt_mode_i; // [RQ21]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= '0;
    end else if (run) begin
      pre_reg <= pre_reg + 3'h1;
    end
  end

  always_comb begin
    if (clock_select == CLK_EXT) begin
      tick = run && HAS_EXT_CLOCK && ext_edge; // [RQ13] [RQ14]
    end else begin
      tick = run && ((pre_reg & pre_mask(clock_select)) ==
                     pre_mask(clock_select)); // [RQ13]
    end
  end

  // Matching runs whatever the pin enables say
  assign match_one = tick && !cmp_one_hold_reg &&
                     (cnt_reg == compare_value_one_reg); // [RQ10]
  assign match_two = tick && !cmp_two_hold_reg &&
                     (cnt_reg == compare_value_two_reg); // [RQ10]
  assign cnt_wr = acc_wr && (is_reg(acc_ok, acc_idx, IDX_CNT_LO) ||
                             is_reg(acc_ok, acc_idx, IDX_ACNT_LO));

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= CNT_RESET;
    end else if (cnt_wr) begin
      cnt_reg <= CNT_RESET; // [RQ23]
    end else if (mode == MODE_SINGLE && cap_one_edge && run) begin
      cnt_reg <= CNT_RESET; // [RQ11]
    end else if (mode == MODE_PWM && match_two) begin
      cnt_reg <= CNT_RESET; // [RQ22] [RQ12]
    end else if (tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  assign force_one = acc_wr && is_reg(acc_ok, acc_idx, IDX_CTRL_ONE) &&
                     dat_i[B_FORCE_ONE];
  assign force_two = acc_wr && is_reg(acc_ok, acc_idx, IDX_CTRL_ONE) &&
                     dat_i[B_FORCE_TWO];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_reg <= CTRL_RESET;
      ctrl_two_reg <= CTRL_RESET;
      timer_disable_reg <= 1'b0;
    end else if (acc_wr) begin
      if (acc_idx == IDX_CTRL_ONE) begin
        ctrl_one_reg <= dat_i[7:0];
      end
      if (acc_idx == IDX_CTRL_TWO) begin
        ctrl_two_reg <= dat_i[7:0];
      end
      if (acc_idx == IDX_STATUS) begin
        timer_disable_reg <= dat_i[B_TIMER_DISABLE]; // [RQ21]
      end
    end
  end

  // Writing the high byte holds matching off until the low byte lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_value_one_reg <= CMP_RESET;
      compare_value_two_reg <= CMP_RESET;
      cmp_one_hold_reg <= 1'b0;
      cmp_two_hold_reg <= 1'b0;
    end else if (acc_wr) begin
      unique case (acc_idx)
        IDX_CMP1_HI: begin
          compare_value_one_reg[15:8] <= dat_i[7:0];
          cmp_one_hold_reg <= 1'b1;
        end
        IDX_CMP1_LO: begin
          compare_value_one_reg[7:0] <= dat_i[7:0];
          cmp_one_hold_reg <= 1'b0;
        end
        IDX_CMP2_HI: begin
          compare_value_two_reg[15:8] <= dat_i[7:0];
          cmp_two_hold_reg <= 1'b1;
        end
        IDX_CMP2_LO: begin
          compare_value_two_reg[7:0] <= dat_i[7:0];
          cmp_two_hold_reg <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Captures; capture pin one belongs to the pulse modes there
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_one_reg <= CAP_RESET;
      capture_two_reg <= CAP_RESET;
    end else begin
      if (cap_one_edge && mode == MODE_NORMAL) begin
        capture_one_reg <= cnt_reg;
      end
      if (cap_two_edge) begin
        capture_two_reg <= cnt_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_out_one_o <= 1'b0;
    end else if (force_one) begin
      compare_out_one_o <= dat_i[B_LEVEL_ONE]; // [RQ6]
    end else begin
      unique case (mode)
        MODE_NORMAL: begin
          if (match_one) begin
            compare_out_one_o <= ctrl_one_reg[B_LEVEL_ONE]; // [RQ9]
          end
        end
        MODE_SINGLE: begin
          if (cap_one_edge && run) begin
            compare_out_one_o <= ctrl_one_reg[B_LEVEL_TWO]; // [RQ11] [RQ7]
          end else if (match_one) begin
            compare_out_one_o <= ctrl_one_reg[B_LEVEL_ONE]; // [RQ11]
          end
        end
        MODE_PWM: begin
          if (match_two) begin
            compare_out_one_o <= ctrl_one_reg[B_LEVEL_TWO]; // [RQ12] [RQ7]
          end else if (match_one) begin
            compare_out_one_o <= ctrl_one_reg[B_LEVEL_ONE]; // [RQ12]
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_out_two_o <= 1'b0;
    end else if (force_two) begin
      compare_out_two_o <= dat_i[B_LEVEL_TWO]; // [RQ5]
    end else if (match_two && mode == MODE_NORMAL) begin
      compare_out_two_o <= ctrl_one_reg[B_LEVEL_TWO]; // [RQ7]
    end
  end

  // Pin enables only hand the pins to the timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_out_one_oe_o <= 1'b0;
      compare_out_two_oe_o <= 1'b0;
    end else begin
      compare_out_one_oe_o <= ctrl_two_reg[B_CMP_ONE_PIN_EN] &&
                              !timer_disable_reg; // [RQ10] [RQ21]
      compare_out_two_oe_o <= ctrl_two_reg[B_CMP_TWO_PIN_EN] &&
                              !timer_disable_reg &&
                              mode == MODE_NORMAL; // [RQ10] [RQ21]
    end
  end

  // ----------------------------------------------------------------
  // Event flags and two-step clear
  // ----------------------------------------------------------------
  always_comb begin
    flag_set = '0;
    flag_set[F_CAP_ONE] = (cap_one_edge && mode != MODE_PWM) ||
                          (match_two && mode == MODE_PWM); // [RQ16]
    flag_set[F_CMP_ONE] = match_one && mode == MODE_NORMAL; // [RQ17]
    flag_set[F_OVF] = tick && (cnt_reg == CNT_MAX); // [RQ18]
    flag_set[F_CAP_TWO] = cap_two_edge; // [RQ19]
    flag_set[F_CMP_TWO] = match_two && mode != MODE_PWM; // [RQ20]
  end

  // Alternate counter low byte is deliberately absent here
  always_comb begin
    flag_hit = '0;
    flag_hit[F_CAP_ONE] = is_reg(acc_ok, acc_idx, IDX_CAP1_LO);
    flag_hit[F_CMP_ONE] = is_reg(acc_ok, acc_idx, IDX_CMP1_LO);
    flag_hit[F_OVF] = is_reg(acc_ok, acc_idx, IDX_CNT_LO); // [RQ18]
    flag_hit[F_CAP_TWO] = is_reg(acc_ok, acc_idx, IDX_CAP2_LO);
    flag_hit[F_CMP_TWO] = is_reg(acc_ok, acc_idx, IDX_CMP2_LO);
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= '0;
      armed_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_FLAGS; i++) begin
        if (flag_set[i]) begin
          flags_reg[i] <= 1'b1;
        end else if (flag_hit[i] && armed_reg[i]) begin
          flags_reg[i] <= 1'b0; // [RQ24]
        end
        if (is_reg(acc_rd, acc_idx, IDX_STATUS) && flags_reg[i]) begin
          armed_reg[i] <= 1'b1; // [RQ24]
        end else if (flag_hit[i]) begin
          armed_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and wake-up
  // ----------------------------------------------------------------
  assign irq_req = !cpu_irq_mask_i && ( // [RQ1]
    (ctrl_one_reg[B_CAP_IRQ_EN] &&
     (flags_reg[F_CAP_ONE] || flags_reg[F_CAP_TWO])) || // [RQ3]
    (ctrl_one_reg[B_CMP_IRQ_EN] &&
     (flags_reg[F_CMP_ONE] || flags_reg[F_CMP_TWO])) || // [RQ4]
    (ctrl_one_reg[B_OVF_IRQ_EN] && flags_reg[F_OVF])); // [RQ4]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      irq_o <= irq_req;
      wake_o <= irq_req && wait_mode_i && !halt_mode_i; // [RQ2]
    end
  end

  // ----------------------------------------------------------------
  // Bus answer; unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= acc;
      if (acc_rd) begin
        unique case (acc_idx)
          IDX_CTRL_ONE: dat_o <= {24'h000000, ctrl_one_reg};
          IDX_CTRL_TWO: dat_o <= {24'h000000, ctrl_two_reg};
          IDX_STATUS: dat_o <= {24'h000000, flags_reg, timer_disable_reg,
                                RSVD_BITS}; // [RQ21]
          IDX_CAP1_HI: dat_o <= {24'h000000, capture_one_reg[15:8]};
          IDX_CAP1_LO: dat_o <= {24'h000000, capture_one_reg[7:0]};
          IDX_CMP1_HI: dat_o <= {24'h000000, compare_value_one_reg[15:8]};
          IDX_CMP1_LO: dat_o <= {24'h000000, compare_value_one_reg[7:0]};
          IDX_CNT_HI, IDX_ACNT_HI: dat_o <= {24'h000000, cnt_reg[15:8]};
          IDX_CNT_LO, IDX_ACNT_LO: dat_o <= {24'h000000, cnt_reg[7:0]};
          IDX_CAP2_HI: dat_o <= {24'h000000, capture_two_reg[15:8]};
          IDX_CAP2_LO: dat_o <= {24'h000000, capture_two_reg[7:0]};
          IDX_CMP2_HI: dat_o <= {24'h000000, compare_value_two_reg[15:8]};
          IDX_CMP2_LO: dat_o <= {24'h000000, compare_value_two_reg[7:0]};
          default: dat_o <= '0;
        endcase
      end else if (acc) begin
        dat_o <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  mask_blocks_irq_a: assert property ( // [RQ1]
    cpu_irq_mask_i |=> !irq_o) else $error("irq while masked");
  halt_no_wake_a: assert property ( // [RQ2]
    halt_mode_i |=> !wake_o) else $error("wake from halt");
  capture_irq_a: assert property ( // [RQ3]
    (!cpu_irq_mask_i && ctrl_one_reg[B_CAP_IRQ_EN] &&
     flags_reg[F_CAP_TWO]) |=> irq_o) else $error("capture irq missing");
  overflow_irq_a: assert property ( // [RQ4]
    (!cpu_irq_mask_i && ctrl_one_reg[B_OVF_IRQ_EN] && flags_reg[F_OVF])
    |=> irq_o) else $error("overflow irq missing");
  force_two_a: assert property ( // [RQ5]
    force_two |=> compare_out_two_o == $past(dat_i[B_LEVEL_TWO]))
    else $error("forced level two not output");
  overflow_set_a: assert property ( // [RQ18]
    (tick && cnt_reg == CNT_MAX && mode == MODE_NORMAL && !cnt_wr)
    |=> flags_reg[F_OVF] && cnt_reg == '0)
    else $error("overflow not flagged");
  alt_keeps_ovf_a: assert property ( // [RQ18]
    (is_reg(acc_ok, acc_idx, IDX_ACNT_LO) && flags_reg[F_OVF])
    |=> flags_reg[F_OVF]) else $error("alternate access cleared overflow");
  pwm_reload_a: assert property ( // [RQ22]
    (mode == MODE_PWM && match_two && !cnt_wr)
    |=> cnt_reg == CNT_RESET && flags_reg[F_CAP_ONE])
    else $error("pwm period not restarted");
  cnt_write_a: assert property ( // [RQ23]
    cnt_wr |=> cnt_reg == CNT_RESET) else $error("counter not reset");
  disable_freeze_a: assert property ( // [RQ21]
    (timer_disable_reg && !cnt_wr && !(mode == MODE_SINGLE))
    |=> $stable(cnt_reg) && !compare_out_one_oe_o)
    else $error("disabled timer still running");
  two_step_clear_a: assert property ( // [RQ24]
    (flag_hit[F_CMP_ONE] && armed_reg[F_CMP_ONE] && !flag_set[F_CMP_ONE])
    |=> !flags_reg[F_CMP_ONE]) else $error("flag not cleared");

  pwm_cycle_c: cover property (mode == MODE_PWM && match_two);
  single_pulse_c: cover property (mode == MODE_SINGLE && cap_one_edge);
  flag_clear_c: cover property ($fell(flags_reg[F_OVF]));
  wake_c: cover property (wake_o);

endmodule
`default_nettype wire

// *** inc/timer_ctl_pkg.sv ***
// Constants, register map and field layout of the 16-bit timer control block
//
// Notes on behaviour
// [RQ1] All timer events share one gated request
// [RQ2] Requests wake from wait, never from halt
// [RQ3] Capture enable gates both capture flags
// [RQ4] Compare and overflow enables gate their flags
// [RQ5] Force bit two copies level two out
// [RQ6] Force bit one copies level one out
// [RQ7] Compare two match drives level two
// [RQ8] Edge select bits pick capture trigger edge
// [RQ9] Compare one match drives level one
// [RQ10] Pin enables gate pins only, not matching
// [RQ11] Single pulse started by capture one edge
// [RQ12] PWM: pulse from compare one, period two
// [RQ13] Clock select: div4, div2, div8, external
// [RQ14] No external pin: external setting stops counter
// [RQ15] External edge bit picks counting transition
// [RQ16] Capture one flag: capture or PWM period
// [RQ17] Compare one flag set on equality, in normal mode only
// [RQ18] Overflow flag; alternate low byte keeps it
// [RQ19] Capture two flag set on capture two
// [RQ20] Compare two flag set on equality, except in PWM
// [RQ21] Disable freezes counting, outputs; reserved bits zero
// [RQ22] PWM period match reloads counter to FFFC
// [RQ23] Counter low byte writes reset counter
// [RQ24] Status read arms clear; low access clears
package timer_ctl_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int IDX_W = 5;
  localparam int IDX_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_CTRL_TWO = 5'h11;
  localparam logic [IDX_W-1:0] IDX_CTRL_ONE = 5'h12;
  localparam logic [IDX_W-1:0] IDX_STATUS = 5'h13;
  localparam logic [IDX_W-1:0] IDX_CAP1_HI = 5'h14;
  localparam logic [IDX_W-1:0] IDX_CAP1_LO = 5'h15;
  localparam logic [IDX_W-1:0] IDX_CMP1_HI = 5'h16;
  localparam logic [IDX_W-1:0] IDX_CMP1_LO = 5'h17;
  localparam logic [IDX_W-1:0] IDX_CNT_HI = 5'h18;
  localparam logic [IDX_W-1:0] IDX_CNT_LO = 5'h19;
  localparam logic [IDX_W-1:0] IDX_ACNT_HI = 5'h1a;
  localparam logic [IDX_W-1:0] IDX_ACNT_LO = 5'h1b;
  localparam logic [IDX_W-1:0] IDX_CAP2_HI = 5'h1c;
  localparam logic [IDX_W-1:0] IDX_CAP2_LO = 5'h1d;
  localparam logic [IDX_W-1:0] IDX_CMP2_HI = 5'h1e;
  localparam logic [IDX_W-1:0] IDX_CMP2_LO = 5'h1f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Control one
  localparam int B_CAP_IRQ_EN = 7;
  localparam int B_CMP_IRQ_EN = 6;
  localparam int B_OVF_IRQ_EN = 5;
  localparam int B_FORCE_TWO = 4;
  localparam int B_FORCE_ONE = 3;
  localparam int B_LEVEL_TWO = 2;
  localparam int B_CAP_ONE_EDGE = 1;
  localparam int B_LEVEL_ONE = 0;
  // Control two
  localparam int B_CMP_ONE_PIN_EN = 7;
  localparam int B_CMP_TWO_PIN_EN = 6;
  localparam int B_SINGLE_PULSE = 5;
  localparam int B_PWM = 4;
  localparam int B_CLK_SEL_HI = 3;
  localparam int B_CLK_SEL_LO = 2;
  localparam int B_CAP_TWO_EDGE = 1;
  localparam int B_EXT_EDGE = 0;
  // Flag vector order, equal to status bits 7..3
  localparam int F_CAP_ONE = 4;
  localparam int F_CMP_ONE = 3;
  localparam int F_OVF = 2;
  localparam int F_CAP_TWO = 1;
  localparam int F_CMP_TWO = 0;
  localparam int NUM_FLAGS = 5;
  localparam int B_TIMER_DISABLE = 2;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [1:0] RSVD_BITS = 2'b00;
  localparam logic [1:0] CLK_DIV4 = 2'b00;
  localparam logic [1:0] CLK_DIV2 = 2'b01;
  localparam logic [1:0] CLK_DIV8 = 2'b10;
  localparam logic [1:0] CLK_EXT = 2'b11;
  localparam logic [2:0] PRE_MASK_DIV2 = 3'h1;
  localparam logic [2:0] PRE_MASK_DIV4 = 3'h3;
  localparam logic [2:0] PRE_MASK_DIV8 = 3'h7;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_PWM = 2'b10
  } timer_mode_t;

endpackage

// *** dv/timer_pins_model.sv ***
// Far-side pin model: capture sources, external clock and compare pin wires
`default_nettype none
module timer_pins_model (
  input wire logic clk_i,
  input wire logic cap_one_lvl_i,
  input wire logic cap_two_lvl_i,
  input wire logic ext_run_i,
  input wire logic out_one_i,
  input wire logic out_one_oe_i,
  input wire logic out_two_i,
  input wire logic out_two_oe_i,
  output logic capture_in_one_o,
  output logic capture_in_two_o,
  output logic ext_clock_pin_o,
  output logic pin_one_o,
  output logic pin_two_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_reg = 2'b00;
  always @(posedge clk_i) div_reg <= div_reg + 2'd1;
  assign capture_in_one_o = cap_one_lvl_i;
  assign capture_in_two_o = cap_two_lvl_i;
  // Source clock stands low while stopped, else a quarter of core rate
  assign ext_clock_pin_o = ext_run_i & div_reg[1];
  // Freed pins fall back to the board pull-up
  assign pin_one_o = out_one_oe_i ? out_one_i : 1'b1;
  assign pin_two_o = out_two_oe_i ? out_two_i : 1'b1;
endmodule
`default_nettype wire

// *** dv/tb_timer_control_status_irq.sv ***
// Self-checking bench for the timer control, status and event block
`default_nettype none
module tb_timer_control_status_irq;
  import timer_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h1;
  logic cap1 = 1'b0, cap2 = 1'b1, ext_run = 1'b0;
  logic cpu_irq_mask_i = 1'b1, wait_mode_i = 1'b0, halt_mode_i = 1'b0;
  wire logic [31:0] dat_o;
  wire logic ack_o, irq_o, wake_o, c1, c1_oe, c2, c2_oe, p1, p2, i1, i2, ex;
  int failures = 0, check_count = 0, cycles = 0;
  logic [7:0] q;
  logic [4:0] ridx [7] = '{IDX_CNT_HI, IDX_STATUS, IDX_CTRL_ONE,
    IDX_CTRL_TWO, IDX_CMP1_HI, IDX_CMP2_LO, 5'h03};
  logic [7:0] rval [7] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
  always #20 clk_i = ~clk_i;
  timer_control_status_irq dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .capture_in_one_i(i1),
    .capture_in_two_i(i2), .ext_clock_pin_i(ex),
    .cpu_irq_mask_i(cpu_irq_mask_i), .wait_mode_i(wait_mode_i),
    .halt_mode_i(halt_mode_i), .compare_out_one_o(c1),
    .compare_out_one_oe_o(c1_oe), .compare_out_two_o(c2),
    .compare_out_two_oe_o(c2_oe), .irq_o(irq_o), .wake_o(wake_o));
  timer_pins_model pins_u (.clk_i(clk_i), .cap_one_lvl_i(cap1),
    .cap_two_lvl_i(cap2), .ext_run_i(ext_run), .out_one_i(c1),
    .out_one_oe_i(c1_oe), .out_two_i(c2), .out_two_oe_i(c2_oe),
    .capture_in_one_o(i1), .capture_in_two_o(i2), .ext_clock_pin_o(ex),
    .pin_one_o(p1), .pin_two_o(p2));
  task automatic bus(input logic [4:0] i, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {1'b0, i, 2'b00};
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic t_reset;
    bus(5'h03, 1'b1, 8'hff);
    foreach (ridx[k]) begin
      bus(ridx[k], 1'b0, 8'h00);
      chk(q, rval[k]);
    end
    $display("%m done");
  endtask
  task automatic t_force;
    logic [7:0] s;
    bus(IDX_CTRL_TWO, 1'b1, 8'hc0);
    bus(IDX_CTRL_ONE, 1'b1, 8'h1d);
    @(posedge clk_i);
    chk({2'b00, c1, c1_oe, c2, c2_oe, p1, p2}, 8'h3f);
    bus(IDX_CTRL_ONE, 1'b1, 8'h18);
    @(posedge clk_i);
    chk({2'b00, c1, c1_oe, c2, c2_oe, p1, p2}, 8'h14);
    bus(IDX_CTRL_TWO, 1'b1, 8'h00);
    @(posedge clk_i);
    chk({4'h0, c1_oe, c2_oe, p1, p2}, 8'h03);
    bus(IDX_CTRL_TWO, 1'b1, 8'hc0);
    bus(IDX_STATUS, 1'b1, 8'h04);
    @(posedge clk_i);
    chk({6'h0, c1_oe, c2_oe}, 8'h00);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h07, 8'h04);
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    s = q;
    repeat (12) @(posedge clk_i);
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    chk(q, s);
    bus(IDX_STATUS, 1'b1, 8'h00);
    $display("%m done");
  endtask
  task automatic t_ovf;
    bus(IDX_CTRL_TWO, 1'b1, 8'h04);
    bus(IDX_CTRL_ONE, 1'b1, 8'h20);
    bus(IDX_STATUS, 1'b0, 8'h00);
    bus(IDX_CNT_LO, 1'b1, 8'h00);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h20, 8'h00);
    repeat (20) @(posedge clk_i);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h20, 8'h20);
    chk({7'h0, irq_o}, 8'h00);
    cpu_irq_mask_i <= 1'b0;
    wait_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({6'h0, irq_o, wake_o}, 8'h03);
    halt_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({7'h0, wake_o}, 8'h00);
    halt_mode_i <= 1'b0;
    wait_mode_i <= 1'b0;
    bus(IDX_ACNT_LO, 1'b0, 8'h00);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h20, 8'h20);
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h20, 8'h00);
    chk({7'h0, irq_o}, 8'h00);
    $display("%m done");
  endtask
  task automatic t_cap;
    bus(IDX_CTRL_ONE, 1'b1, 8'h82);
    cap1 <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h01);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h90, 8'h80);
    cap2 <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(IDX_CAP1_LO, 1'b0, 8'h00);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h90, 8'h10);
    bus(IDX_CTRL_ONE, 1'b1, 8'h00);
    @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    cap1 <= 1'b0;
    bus(IDX_CAP2_LO, 1'b0, 8'h00);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h90, 8'h80);
    $display("%m done");
  endtask
  task automatic t_cmp;
    bus(IDX_CMP1_HI, 1'b1, 8'h00);
    bus(IDX_CMP1_LO, 1'b1, 8'h03);
    bus(IDX_CMP2_HI, 1'b1, 8'h00);
    bus(IDX_CMP2_LO, 1'b1, 8'h05);
    bus(IDX_CTRL_TWO, 1'b1, 8'hc4);
    bus(IDX_CTRL_ONE, 1'b1, 8'h45);
    bus(IDX_CNT_LO, 1'b1, 8'h00);
    repeat (30) @(posedge clk_i);
    chk({6'h0, c1, c2}, 8'h03);
    chk({7'h0, irq_o}, 8'h01);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h48, 8'h48);
    bus(IDX_CMP1_LO, 1'b0, 8'h00);
    bus(IDX_CMP2_LO, 1'b0, 8'h00);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'h48, 8'h00);
    bus(IDX_CAP1_LO, 1'b0, 8'h00);
    bus(IDX_CTRL_TWO, 1'b1, 8'h94);
    bus(IDX_CNT_LO, 1'b1, 8'h00);
    repeat (30) @(posedge clk_i);
    bus(IDX_STATUS, 1'b0, 8'h00);
    chk(q & 8'hc8, 8'h80);
    bus(IDX_CTRL_ONE, 1'b1, 8'h06);
    bus(IDX_CTRL_TWO, 1'b1, 8'ha4);
    cap1 <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({7'h0, c1}, 8'h01);
    repeat (30) @(posedge clk_i);
    chk({7'h0, c1}, 8'h00);
    $display("%m done");
  endtask
  task automatic t_ext;
    bus(IDX_CTRL_TWO, 1'b1, 8'h0d);
    bus(IDX_CNT_LO, 1'b1, 8'h00);
    repeat (20) @(posedge clk_i);
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    chk(q, 8'hfc);
    ext_run <= 1'b1;
    repeat (40) @(posedge clk_i);
    bus(IDX_CNT_HI, 1'b0, 8'h00);
    chk(q, 8'h00);
    ext_run <= 1'b0;
    $display("%m done");
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 4000) begin
      failures++;
      end_of_test;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_force;
    t_ovf;
    t_cap;
    t_cmp;
    t_ext;
    end_of_test;
  end
endmodule
`default_nettype wire
